// ===== rtl/hmc_regs.sv
`timescale 1ns/1ps
module hmc_regs #(
  parameter int SOF_DELAY_CYC = hmc_pkg::SOF_DELAY_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_CMD,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_RESUME_SEEN_FLAG,
  input wire logic I_DOWNSTREAM_RESUME,
  input wire logic I_EOF,
  input wire logic I_PERIODIC_DONE,
  output logic [31:0] O_RDATA,
  output logic O_RDATA_VALID,
  output logic [1:0] O_HOST_FUNCTIONAL_STATE,
  output logic O_REMOTE_WAKE,
  output logic O_SOF_RUN,
  output logic O_OVERRUN_FLAG_SET,
  output logic O_ROOT_HUB_RESET,
  output logic O_SOFT_RESET_BUSY
);
  localparam int SRST_BOUND = hmc_pkg::SRST_MAX_CYC;

  hmc_pkg::hmc_fs_e fs_reg;
  hmc_pkg::hmc_fs_e fs_next;
  logic wen_reg, wen_next;
  logic wconn_reg, wconn_next;
  logic srst_reg, srst_next;
  logic [3:0] srst_cnt_reg, srst_cnt_next;
  logic [1:0] soc_reg, soc_next;
  logic resume_meta_reg, resume_sync_reg, resume_prev_reg;
  logic wake_reg;
  logic overrun_set_reg;
  logic rh_reset_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg;

  // command decode; control writes are held off while the soft reset runs
  wire wr_ctrl = I_WR && (I_CMD == hmc_pkg::CMD_WR_CTRL) && !srst_reg;
  wire wr_cmdst = I_WR && (I_CMD == hmc_pkg::CMD_WR_CMDST);
  wire rd_ctrl = (I_CMD == hmc_pkg::CMD_RD_CTRL);
  wire rd_cmdst = (I_CMD == hmc_pkg::CMD_RD_CMDST);
  wire srst_set = wr_cmdst && I_WDATA[hmc_pkg::CMDST_SRST_BIT];
  wire srst_done = srst_reg && (srst_cnt_reg == hmc_pkg::SRST_CYC - 4'h1);
  wire resume_rise = resume_sync_reg && !resume_prev_reg;
  wire overrun = I_EOF && !I_PERIODIC_DONE;
  wire [1:0] wr_fs = I_WDATA[hmc_pkg::CTRL_FS_LSB +: 2];

  // readback images, reserved bits zero
  wire [31:0] ctrl_word = (32'(wen_reg) << hmc_pkg::CTRL_WEN_BIT) | (32'(wconn_reg) << hmc_pkg::CTRL_WCONN_BIT)
    | (32'(fs_reg) << hmc_pkg::CTRL_FS_LSB);
  wire [31:0] cmdst_word = (32'(soc_reg) << hmc_pkg::CMDST_SOC_LSB)
    | (32'(srst_reg) << hmc_pkg::CMDST_SRST_BIT);

  assign fs_next = srst_reg ? hmc_pkg::HMC_FS_RESET :
    wr_ctrl ? hmc_pkg::hmc_fs_e'(wr_fs) :
    ((fs_reg == hmc_pkg::HMC_FS_SUSPEND) && resume_rise) ? hmc_pkg::HMC_FS_RESUME : fs_reg;
  assign wen_next = wr_ctrl ? I_WDATA[hmc_pkg::CTRL_WEN_BIT] : wen_reg;
  assign wconn_next = wr_ctrl ? I_WDATA[hmc_pkg::CTRL_WCONN_BIT] : wconn_reg;
  assign srst_next = srst_set || (srst_reg && !srst_done);
  assign srst_cnt_next = (srst_reg && !srst_done && !srst_set) ? srst_cnt_reg + 4'h1 : 4'h0;
  assign soc_next = srst_reg ? 2'h0 : overrun ? soc_reg + 2'h1 : soc_reg;
  assign rdata_next = rd_ctrl ? ctrl_word : rd_cmdst ? cmdst_word : 32'h0000_0000;

  hmc_sof_timer #(
    .SOF_DELAY_CYC(SOF_DELAY_CYC)
  ) i_hmc_sof_timer (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_run(fs_reg == hmc_pkg::HMC_FS_OPER),
    .o_expired(O_SOF_RUN)
  );

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      fs_reg <= hmc_pkg::HMC_FS_RESET;
      wen_reg <= hmc_pkg::CTRL_RESET[hmc_pkg::CTRL_WEN_BIT];
      wconn_reg <= hmc_pkg::CTRL_RESET[hmc_pkg::CTRL_WCONN_BIT];
      srst_reg <= hmc_pkg::CMDST_RESET[hmc_pkg::CMDST_SRST_BIT];
      srst_cnt_reg <= 4'h0;
      soc_reg <= hmc_pkg::CMDST_RESET[hmc_pkg::CMDST_SOC_LSB +: 2];
    end else begin
      fs_reg <= fs_next;
      wen_reg <= wen_next;
      wconn_reg <= wconn_next;
      srst_reg <= srst_next;
      srst_cnt_reg <= srst_cnt_next;
      soc_reg <= soc_next;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      resume_meta_reg <= 1'b0;
      resume_sync_reg <= 1'b0;
      resume_prev_reg <= 1'b0;
      wake_reg <= 1'b0;
      overrun_set_reg <= 1'b0;
      rh_reset_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      resume_meta_reg <= I_DOWNSTREAM_RESUME;
      resume_sync_reg <= resume_meta_reg;
      resume_prev_reg <= resume_sync_reg;
      wake_reg <= wen_reg && I_RESUME_SEEN_FLAG;
      overrun_set_reg <= overrun;
      rh_reset_reg <= 1'b0;
      rdata_reg <= rdata_next;
      rvalid_reg <= I_RD;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_RDATA_VALID = rvalid_reg;
  assign O_HOST_FUNCTIONAL_STATE = fs_reg;
  assign O_REMOTE_WAKE = wake_reg;
  assign O_OVERRUN_FLAG_SET = overrun_set_reg;
  assign O_ROOT_HUB_RESET = rh_reset_reg;
  assign O_SOFT_RESET_BUSY = srst_reg;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  property p_wen_host_only;
    !wr_ctrl |=> $stable(wen_reg);
  endproperty
  a_wen_host_only: assert property (p_wen_host_only) else $error("enable bit changed without write");

  property p_remote_wake;
    (wen_reg && I_RESUME_SEEN_FLAG) |=> O_REMOTE_WAKE;
  endproperty
  a_remote_wake: assert property (p_remote_wake) else $error("remote wake not signalled");

  property p_no_wake;
    !wen_reg |=> !O_REMOTE_WAKE;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("remote wake while disabled");

  property p_wconn_soft;
    (srst_reg && !wr_ctrl) |=> $stable(wconn_reg);
  endproperty
  a_wconn_soft: assert property (p_wconn_soft) else $error("connected bit altered by soft reset");

  property p_fs_self;
    ($changed(fs_reg) && !$past(wr_ctrl) && !$past(srst_reg)) |-> $past(fs_reg) == hmc_pkg::HMC_FS_SUSPEND;
  endproperty
  a_fs_self: assert property (p_fs_self) else $error("state changed by device outside suspend");

  // frame start is registered, so it drops one cycle after operational is left
  property p_sof_oper;
    O_SOF_RUN |-> $past(fs_reg) == hmc_pkg::HMC_FS_OPER;
  endproperty
  a_sof_oper: assert property (p_sof_oper) else $error("frame start outside operational");

  property p_sof_late;
    $rose(fs_reg == hmc_pkg::HMC_FS_OPER) |-> !O_SOF_RUN [*8];
  endproperty
  a_sof_late: assert property (p_sof_late) else $error("frame start too early");

  property p_resume;
    (fs_reg == hmc_pkg::HMC_FS_SUSPEND && resume_rise && !wr_ctrl && !srst_reg)
      |=> fs_reg == hmc_pkg::HMC_FS_RESUME;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after downstream resume");

  property p_srst_fs;
    srst_reg |=> fs_reg == hmc_pkg::HMC_FS_RESET;
  endproperty
  a_srst_fs: assert property (p_srst_fs) else $error("state not reset by soft reset");

  // a soft reset must leave the root hub and its downstream ports alone
  property p_rh_soft;
    srst_reg |-> !O_ROOT_HUB_RESET;
  endproperty
  a_rh_soft: assert property (p_rh_soft) else $error("root hub reset by soft reset");

  property p_wr_set;
    srst_set |=> srst_reg;
  endproperty
  a_wr_set: assert property (p_wr_set) else $error("written one not set");

  property p_srst_done;
    ($rose(srst_reg) ##1 !srst_set [*8]) |-> ##[0:SRST_BOUND] !srst_reg;
  endproperty
  a_srst_done: assert property (p_srst_done) else $error("soft reset not finished");

  property p_soc;
    (overrun && !srst_reg) |=> (soc_reg == 2'($past(soc_reg) + 2'h1)) && O_OVERRUN_FLAG_SET;
  endproperty
  a_soc: assert property (p_soc) else $error("overrun not counted");

  property p_soc_hold;
    (!overrun && !srst_reg) |=> $stable(soc_reg) && !O_OVERRUN_FLAG_SET;
  endproperty
  a_soc_hold: assert property (p_soc_hold) else $error("counter moved without overrun");

  c_resume: cover property (fs_reg == hmc_pkg::HMC_FS_SUSPEND ##1 fs_reg == hmc_pkg::HMC_FS_RESUME);
  c_srst: cover property ($fell(srst_reg));
  c_wrap: cover property (soc_reg == 2'h3 ##1 soc_reg == 2'h0);
  c_sof: cover property ($rose(O_SOF_RUN));
  c_wake: cover property ($rose(O_REMOTE_WAKE));
endmodule : hmc_regs

// ===== rtl/hmc_pkg.sv
package hmc_pkg;
  // command codes: read codes, write codes carry bit 7
  localparam logic [7:0] CMD_RD_CTRL = 8'h01;
  localparam logic [7:0] CMD_RD_CMDST = 8'h02;
  localparam logic [7:0] CMD_WR_CTRL = 8'h81;
  localparam logic [7:0] CMD_WR_CMDST = 8'h82;
  // host_mode_control fields
  localparam int CTRL_FS_LSB = 6;
  localparam int CTRL_WCONN_BIT = 9;
  localparam int CTRL_WEN_BIT = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // host_command_status fields
  localparam int CMDST_SRST_BIT = 0;
  localparam int CMDST_SOC_LSB = 16;
  localparam logic [31:0] CMDST_RESET = 32'h0000_0000;
  // functional state encoding
  typedef enum logic [1:0] {
    HMC_FS_RESET = 2'b00,
    HMC_FS_RESUME = 2'b01,
    HMC_FS_OPER = 2'b10,
    HMC_FS_SUSPEND = 2'b11
  } hmc_fs_e;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOF_DELAY_NS = 1000000;
  localparam int SOF_DELAY_CYC = SOF_DELAY_NS / CLK_PERIOD_NS;
  localparam int SRST_MAX_NS = 10000;
  localparam int SRST_MAX_CYC = SRST_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SRST_CYC = 4'h8;
  localparam int SOF_CNT_W = 17;
endpackage : hmc_pkg

// ===== rtl/hmc_sof_timer.sv
`timescale 1ns/1ps
module hmc_sof_timer #(
  parameter int SOF_DELAY_CYC = hmc_pkg::SOF_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_expired
);
  logic [hmc_pkg::SOF_CNT_W-1:0] cnt_reg;
  logic [hmc_pkg::SOF_CNT_W-1:0] cnt_next;
  logic expired_reg;
  logic expired_next;
  wire last_cnt = (cnt_reg == hmc_pkg::SOF_CNT_W'(SOF_DELAY_CYC - 1));

  // counts from entry to operational; any exit restarts the wait
  assign cnt_next = (!i_run || expired_reg) ? '0 : cnt_reg + hmc_pkg::SOF_CNT_W'(1);
  assign expired_next = i_run && (expired_reg || last_cnt);
  assign o_expired = expired_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expired_reg <= expired_next;
    end
  end
endmodule : hmc_sof_timer

// ===== verification/hmc_host_model.sv
`timescale 1ns/1ps
module hmc_host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rdata_valid,
  output logic [7:0] o_cmd,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata
);
  initial begin
    o_cmd = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0000_0000;
  end
  // released data lines show the inverse of the last word
  task automatic wr(input logic [7:0] cmd, input logic [31:0] data);
    @(posedge i_clk);
    o_cmd <= cmd;
    o_wdata <= data;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~data;
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [31:0] data);
    @(posedge i_clk);
    o_cmd <= cmd;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    data = (i_rdata_valid === 1'b1) ? i_rdata : 32'hXXXX_XXXX;
  endtask : rd
  // start-up firmware declares remote wake support
  task automatic post();
    wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0200);
  endtask : post
endmodule : hmc_host_model

// ===== verification/usb_host_mode_command_regs_bench.sv
`timescale 1ns/1ps
module usb_host_mode_command_regs_bench;
  logic clk, rst, seen, dres, eof, pdone, rd, wr, rv, rw, sof, ovf, rhr, busy;
  logic [7:0] cmd;
  logic [31:0] wdata, rdata, v;
  logic [1:0] fs;
  int err_total, num_checks, nflag;
  typedef struct {logic [31:0] wd; logic [31:0] ex;} hmc_row_s;
  hmc_row_s rows[4] = '{'{32'h0000_0480, 32'h0000_0480}, '{32'hFFFF_FFFF, 32'h0000_06C0},
    '{32'h0000_0200, 32'h0000_0200}, '{32'h0000_00C0, 32'h0000_00C0}};
  hmc_regs #(.SOF_DELAY_CYC(20)) i_hmc_regs (.I_CLK_SYS(clk), .I_RST(rst), .I_CMD(cmd), .I_RD(rd),
    .I_WR(wr), .I_WDATA(wdata), .I_RESUME_SEEN_FLAG(seen), .I_DOWNSTREAM_RESUME(dres), .I_EOF(eof),
    .I_PERIODIC_DONE(pdone), .O_RDATA(rdata), .O_RDATA_VALID(rv), .O_HOST_FUNCTIONAL_STATE(fs),
    .O_REMOTE_WAKE(rw), .O_SOF_RUN(sof), .O_OVERRUN_FLAG_SET(ovf), .O_ROOT_HUB_RESET(rhr),
    .O_SOFT_RESET_BUSY(busy));
  hmc_host_model i_hmc_host_model (.i_clk(clk), .i_rdata(rdata), .i_rdata_valid(rv), .o_cmd(cmd),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) if (ovf === 1'b1) nflag++;
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    seen = 1'b0;
    dres = 1'b0;
    eof = 1'b0;
    pdone = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    chk(rhr, 1);
    @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(rhr, 0);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CTRL, v);
    chk(v, hmc_pkg::CTRL_RESET);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CMDST, v);
    chk(v, hmc_pkg::CMDST_RESET);
    $display("reset test done");
    foreach (rows[i]) begin
      i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, rows[i].wd);
      tick(1);
      chk(fs, rows[i].ex[7:6]);
      i_hmc_host_model.rd(hmc_pkg::CMD_RD_CTRL, v);
      chk(v, rows[i].ex);
    end
    i_hmc_host_model.rd(8'h03, v);
    chk(v, 0);
    $display("table test done");
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      eof <= 1'b1;
      pdone <= (k == 5);
    end
    @(posedge clk);
    eof <= 1'b0;
    tick(2);
    chk(nflag, 5);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CMDST, 32'h0003_0000);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CMDST, v);
    chk(v, 32'h0001_0000);
    $display("overrun test done");
    @(posedge clk);
    dres <= 1'b1;
    tick(6);
    chk(fs, 2'b01);
    @(posedge clk);
    dres <= 1'b0;
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0080);
    tick(12);
    chk(sof, 0);
    @(posedge clk);
    dres <= 1'b1;
    tick(14);
    chk(sof, 1);
    chk(fs, 2'b10);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0480);
    seen <= 1'b1;
    tick(2);
    chk(rw, 1);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0080);
    tick(2);
    chk(rw, 0);
    $display("state test done");
    i_hmc_host_model.post();
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0680);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CMDST, 32'h0000_0001);
    tick(1);
    chk(busy, 1);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CMDST, 32'h0000_0000);
    #1;
    chk(busy, 1);
    i_hmc_host_model.wr(hmc_pkg::CMD_WR_CTRL, 32'h0000_0000);
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) tick(1);
    chk(busy, 0);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CTRL, v);
    chk(v, 32'h0000_0600);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CMDST, v);
    chk(v, 0);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    chk(rhr, 1);
    @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(rhr, 0);
    i_hmc_host_model.rd(hmc_pkg::CMD_RD_CTRL, v);
    chk(v, 0);
    $display("soft and hard reset test done");
    finish_test();
  end
endmodule : usb_host_mode_command_regs_bench
